//--- hdl/svcr_defs.svh
`ifndef SVCR_DEFS_SVH
`define SVCR_DEFS_SVH
`define SVCR_OFF_TEST0       8'h68
`define SVCR_OFF_TEST1       8'h6c
`define SVCR_OFF_TIMER       8'h70
`define SVCR_OFF_FWD         8'h74
`define SVCR_RST_TEST0       32'h04001060
`define SVCR_RST_TEST1       32'h04000800
`define SVCR_RST_TIMER       32'h80000000
`define SVCR_RST_FWD         32'h00000002
`define SVCR_TEST0_PRELOAD   32'h00006000
`define SVCR_TIMER_WMASK     32'h7fff1fff
`define SVCR_TIMER_PRELOAD   32'hffff7fff
`define SVCR_FWD_WMASK       32'h0000001f
`define SVCR_FWD_PRELOAD     32'h000000ff
`define SVCR_BIT_ROLE_EN     1
`define SVCR_BIT_NO_HOTRST   2
`define SVCR_BIT_DN_ROLE     3
`define SVCR_BIT_REPLAY_EN   12
`define SVCR_BIT_PM_DIS      13
`define SVCR_BIT_MSI_DIS     14
`define SVCR_BIT_ACK_EN      30
`define SVCR_BIT_VGA         31
`define SVCR_BIT_STORE_FWD   0
`define SVCR_BIT_ARB_STAY    3
`define SVCR_BIT_CRED_ALL    4
`endif

//--- hdl/svcr_pkg.sv
package svcr_pkg;
  typedef enum logic [1:0] {
    SVCR_LD_IDLE = 2'b00,
    SVCR_LD_RUN  = 2'b01,
    SVCR_LD_DONE = 2'b10
  } svcr_load_state_t;
  typedef logic [1:0] svcr_reg_sel_t;
endpackage : svcr_pkg

//--- hdl/svcr_reg_if.sv
`timescale 1ns/1ps
interface svcr_reg_if;
  logic        we;
  logic [31:0] wdata;
  logic [31:0] wmask;
  logic [31:0] q;
  modport owner (input we, input wdata, input wmask, output q);
  modport user  (output we, output wdata, output wmask, input q);
endinterface : svcr_reg_if

//--- hdl/svcr_word.sv
`timescale 1ns/1ps
module svcr_word
  import svcr_pkg::*;
#(
  parameter logic [31:0] RESET_VAL = 32'h00000000
) (
  input  wire logic   ref_clk_i,
  input  wire logic   rst_i,
  input  wire logic   ce_i,
  svcr_reg_if.owner   port
);
  logic [31:0] q;
  logic [31:0] next_q;

  always_comb begin
    next_q = q;
    if (port.we) begin
      next_q = (q & ~port.wmask) | (port.wdata & port.wmask);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q <= RESET_VAL;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  assign port.q = q;
endmodule : svcr_word

//--- hdl/svcr_regs.sv
`timescale 1ns/1ps
`include "svcr_defs.svh"
module svcr_regs
  import svcr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              cfg_wr_i,
  input  wire logic              cfg_rd_i,
  input  wire logic [ADDR_W-1:0] cfg_addr_i,
  input  wire logic [31:0]       cfg_wdata_i,
  input  wire logic [3:0]        cfg_be_i,
  output logic [31:0]            cfg_rdata_o,
  output logic                   cfg_rvalid_o,
  input  wire logic              pre_valid_i,
  input  wire logic [ADDR_W-1:0] pre_addr_i,
  input  wire logic [31:0]       pre_data_i,
  input  wire logic              pre_done_i,
  output logic                   link_train_ok_o,
  output logic                   role_change_en_o,
  output logic                   hot_reset_fwd_o,
  output logic                   downstream_role_select_o,
  output logic [31:0]            test_ctrl1_o,
  output logic [11:0]            replay_timeout_o,
  output logic                   replay_user_en_o,
  output logic                   pm_cap_disable_o,
  output logic                   msi_cap_disable_o,
  output logic [13:0]            ack_latency_o,
  output logic                   ack_user_en_o,
  output logic                   vga_decode_en_o,
  output logic                   store_forward_o,
  output logic [1:0]             ct_threshold_o,
  output logic                   arb_stay_o,
  output logic                   credit_all_types_o
);
  // offsets need at least eight address bits
  generate
    if (ADDR_W < 8) begin : g_addr_check
      $error("svcr_regs: ADDR_W must be at least 8");
    end
  endgenerate

  svcr_reg_if rif [4] ();
  logic [31:0] q [4];

  function automatic svcr_reg_sel_t sel_of(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(`SVCR_OFF_TEST0)) begin
      return 2'd0;
    end else if (a == ADDR_W'(`SVCR_OFF_TEST1)) begin
      return 2'd1;
    end else if (a == ADDR_W'(`SVCR_OFF_TIMER)) begin
      return 2'd2;
    end else begin
      return 2'd3;
    end
  endfunction : sel_of

  function automatic logic hit(input logic [ADDR_W-1:0] a);
    return (a == ADDR_W'(`SVCR_OFF_TEST0)) || (a == ADDR_W'(`SVCR_OFF_TEST1)) ||
           (a == ADDR_W'(`SVCR_OFF_TIMER)) || (a == ADDR_W'(`SVCR_OFF_FWD));
  endfunction : hit

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  localparam logic [31:0] RST_VALS [4] = '{`SVCR_RST_TEST0, `SVCR_RST_TEST1,
                                           `SVCR_RST_TIMER, `SVCR_RST_FWD};
  // software-writable bits per word
  localparam logic [31:0] SW_MASK [4] = '{32'hffffffff, 32'hffffffff,
                                          `SVCR_TIMER_WMASK, `SVCR_FWD_WMASK};
  // preload-writable bits per word
  localparam logic [31:0] PRE_MASK [4] = '{`SVCR_TEST0_PRELOAD, 32'h00000000,
                                           `SVCR_TIMER_PRELOAD, `SVCR_FWD_PRELOAD};

  svcr_load_state_t ld_state;
  svcr_load_state_t next_ld_state;

  always_comb begin
    next_ld_state = ld_state;
    case (ld_state)
      SVCR_LD_IDLE: begin
        next_ld_state = SVCR_LD_RUN;
      end
      SVCR_LD_RUN: begin
        if (pre_done_i) begin
          next_ld_state = SVCR_LD_DONE;
        end
      end
      SVCR_LD_DONE: begin
        next_ld_state = SVCR_LD_DONE;
      end
      default: begin
        next_ld_state = SVCR_LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ld_state <= SVCR_LD_IDLE;
    end else if (ce_i) begin
      ld_state <= next_ld_state;
    end
  end

  logic loading;
  assign loading = (ld_state != SVCR_LD_DONE);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_word
      svcr_word #(
        .RESET_VAL (RST_VALS[g])
      ) u_word (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .port      (rif[g].owner)
      );
      always_comb begin
        if (loading) begin
          rif[g].we    = pre_valid_i && hit(pre_addr_i) && (sel_of(pre_addr_i) == svcr_reg_sel_t'(g));
          rif[g].wdata = pre_data_i;
          rif[g].wmask = PRE_MASK[g];
        end else begin
          rif[g].we    = cfg_wr_i && hit(cfg_addr_i) && (sel_of(cfg_addr_i) == svcr_reg_sel_t'(g));
          rif[g].wdata = cfg_wdata_i;
          rif[g].wmask = SW_MASK[g] & be_mask(cfg_be_i);
        end
      end
      assign q[g] = rif[g].q;
    end
  endgenerate

  logic [31:0] rdata;
  logic        rvalid;
  logic [31:0] next_rdata;
  logic        next_rvalid;

  always_comb begin
    next_rvalid = cfg_rd_i;
    next_rdata  = 32'h00000000;
    if (cfg_rd_i && hit(cfg_addr_i)) begin
      next_rdata = q[sel_of(cfg_addr_i)] & ~((sel_of(cfg_addr_i) == 2'd2) ? 32'h00008000 : 32'h00000000);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata  <= 32'h00000000;
      rvalid <= 1'b0;
    end else if (ce_i) begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  logic active_role;
  logic next_active_role;

  always_comb begin
    next_active_role = active_role;
    if (q[0][`SVCR_BIT_ROLE_EN]) begin
      next_active_role = q[0][`SVCR_BIT_DN_ROLE];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      active_role <= 1'(`SVCR_RST_TEST0 >> `SVCR_BIT_DN_ROLE);
    end else if (ce_i) begin
      active_role <= next_active_role;
    end
  end

  assign cfg_rdata_o  = rdata;
  assign cfg_rvalid_o = rvalid;
  assign link_train_ok_o = !loading;

  assign role_change_en_o         = q[0][`SVCR_BIT_ROLE_EN];
  assign hot_reset_fwd_o          = !q[0][`SVCR_BIT_NO_HOTRST];
  assign downstream_role_select_o = active_role;
  assign test_ctrl1_o             = q[1];
  assign replay_timeout_o         = q[2][11:0];
  assign replay_user_en_o         = q[2][`SVCR_BIT_REPLAY_EN];
  assign pm_cap_disable_o         = q[2][`SVCR_BIT_PM_DIS];
  assign msi_cap_disable_o        = q[2][`SVCR_BIT_MSI_DIS];
  assign ack_latency_o            = q[2][29:16];
  assign ack_user_en_o            = q[2][`SVCR_BIT_ACK_EN];
  assign vga_decode_en_o          = q[2][`SVCR_BIT_VGA];
  assign store_forward_o          = q[3][`SVCR_BIT_STORE_FWD];
  assign ct_threshold_o           = q[3][2:1];
  assign arb_stay_o               = q[3][`SVCR_BIT_ARB_STAY];
  assign credit_all_types_o       = q[3][`SVCR_BIT_CRED_ALL];
endmodule : svcr_regs

//--- verif/svcr_regs_checker.sv
`timescale 1ns/1ps
module svcr_regs_checker
  import svcr_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cfg_wr_i,
  input wire logic        cfg_rd_i,
  input wire logic [7:0]  cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [3:0]  cfg_be_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        cfg_rvalid_o,
  input wire logic        pre_valid_i,
  input wire logic        pre_done_i,
  input wire logic        link_train_ok_o,
  input wire logic        role_change_en_o,
  input wire logic        hot_reset_fwd_o,
  input wire logic        downstream_role_select_o,
  input wire logic [11:0] replay_timeout_o,
  input wire logic [13:0] ack_latency_o,
  input wire logic        ack_user_en_o,
  input wire logic        vga_decode_en_o,
  input wire logic        store_forward_o,
  input wire logic [1:0]  ct_threshold_o
);
  logic wr;
  // config write actually taken
  assign wr = ce_i & cfg_wr_i & link_train_ok_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_rst; $fell(rst_i) && $past(ce_i) |-> vga_decode_en_o && ct_threshold_o == 2'h1
    && !store_forward_o; endproperty
  a_rst: assert property (p_rst) else $error("wrong values after reset");
  property p_role; wr && cfg_addr_i == 8'h68 && cfg_be_i[0] |=> role_change_en_o == $past(cfg_wdata_i[1]); endproperty
  a_role: assert property (p_role) else $error("role enable not written");
  property p_hot; wr && cfg_addr_i == 8'h68 && cfg_be_i[0] |=> hot_reset_fwd_o != $past(cfg_wdata_i[2]); endproperty
  a_hot: assert property (p_hot) else $error("hot reset forward wrong");
  property p_rlk; !role_change_en_o |=> $stable(downstream_role_select_o); endproperty
  a_rlk: assert property (p_rlk) else $error("role changed while locked");
  property p_rpv; wr && cfg_addr_i == 8'h70 && &cfg_be_i[1:0] |=> replay_timeout_o == $past(cfg_wdata_i[11:0]);
  endproperty
  a_rpv: assert property (p_rpv) else $error("replay value not written");
  property p_ack; wr && cfg_addr_i == 8'h70 && &cfg_be_i[3:2] |=> ack_latency_o == $past(cfg_wdata_i[29:16])
    && ack_user_en_o == $past(cfg_wdata_i[30]); endproperty
  a_ack: assert property (p_ack) else $error("ack latency not written");
  property p_vga; wr && cfg_addr_i == 8'h70 |=> $stable(vga_decode_en_o); endproperty
  a_vga: assert property (p_vga) else $error("vga decode bit written");
  property p_fwd; wr && cfg_addr_i == 8'h74 && cfg_be_i[0] |=> store_forward_o == $past(cfg_wdata_i[0])
    && ct_threshold_o == $past(cfg_wdata_i[2:1]); endproperty
  a_fwd: assert property (p_fwd) else $error("forwarding mode not written");
  property p_rd; ce_i && cfg_rd_i && cfg_addr_i == 8'h70 |=> cfg_rvalid_o && !cfg_rdata_o[15]; endproperty
  a_rd: assert property (p_rd) else $error("timer read wrong");
  property p_trn; $rose(link_train_ok_o) |-> $past(pre_done_i) && $past(ce_i); endproperty
  a_trn: assert property (p_trn) else $error("training allowed early");
  c_rd: cover property (cfg_rvalid_o);
  c_pre: cover property (pre_valid_i && ce_i);
  c_wr: cover property (wr);
endmodule : svcr_regs_checker
bind svcr_regs svcr_regs_checker chk_u (.*);

//--- verif/svcr_regs_bench.sv
`timescale 1ns/1ps
module svcr_regs_bench;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        cfg_wr_i = 1'b0, cfg_rd_i = 1'b0, pre_valid_i = 1'b0, pre_done_i = 1'b0;
  logic [7:0]  cfg_addr_i = 8'h00, pre_addr_i = 8'h00;
  logic [31:0] cfg_wdata_i = 32'h0, pre_data_i = 32'h0;
  logic [3:0]  cfg_be_i = 4'h0;
  logic [31:0] cfg_rdata_o, test_ctrl1_o;
  logic [11:0] replay_timeout_o;
  logic [13:0] ack_latency_o;
  logic [1:0]  ct_threshold_o;
  logic        cfg_rvalid_o, link_train_ok_o, role_change_en_o, hot_reset_fwd_o, downstream_role_select_o;
  logic        replay_user_en_o, pm_cap_disable_o, msi_cap_disable_o, ack_user_en_o, vga_decode_en_o;
  logic        store_forward_o, arb_stay_o, credit_all_types_o;
  int          num_errors = 0;
  int          total_checks = 0;
  svcr_regs dut_u (.*);
  always #2 ref_clk_i = ~ref_clk_i;
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] b);
    cfg_addr_i = a;
    cfg_wdata_i = d;
    cfg_be_i = b;
    cfg_wr_i = 1'b1;
    @(negedge ref_clk_i);
    cfg_wr_i = 1'b0;
    @(negedge ref_clk_i);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    cfg_addr_i = a;
    cfg_rd_i = 1'b1;
    @(negedge ref_clk_i);
    cfg_rd_i = 1'b0;
    chk("rvalid", cfg_rvalid_o, 32'h1);
    chk("rdata", cfg_rdata_o, e);
    @(negedge ref_clk_i);
  endtask : rd
  task automatic pl(logic [7:0] a, logic [31:0] d);
    pre_addr_i = a;
    pre_data_i = d;
    pre_valid_i = 1'b1;
    @(negedge ref_clk_i);
    pre_valid_i = 1'b0;
    @(negedge ref_clk_i);
  endtask : pl
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (20) @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rd(8'h68, 32'h04001060);
    rd(8'h6c, 32'h04000800);
    rd(8'h70, 32'h80000000);
    rd(8'h74, 32'h00000002);
    rd(8'h78, 32'h00000000);
    wr(8'h74, 32'h00000001, 4'hf);
    chk("early_sf", store_forward_o, 32'h0);
    chk("early_train", link_train_ok_o, 32'h0);
    pl(8'h68, 32'h0000ffff);
    pl(8'h70, 32'h0000ffff);
    pl(8'h74, 32'h00000005);
    pre_done_i = 1'b1;
    @(negedge ref_clk_i);
    pre_done_i = 1'b0;
    chk("train", link_train_ok_o, 32'h1);
    rd(8'h68, 32'h04007060);
    rd(8'h70, 32'h00007fff);
    chk("msi_dis", {msi_cap_disable_o, pm_cap_disable_o, vga_decode_en_o}, 32'h6);
    chk("fwd_pre", {ct_threshold_o, store_forward_o}, 32'h5);
    for (int i = 0; i < 2; i++) begin
      wr(8'h68, i[0] ? 32'h0000000e : 32'h0, 4'h1);
      chk("role_en", role_change_en_o, i);
      chk("hot_fwd", hot_reset_fwd_o, 1 - i);
      chk("dn_role", downstream_role_select_o, i);
    end
    wr(8'h68, 32'h00000000, 4'h1);
    chk("dn_hold", downstream_role_select_o, 32'h1);
    wr(8'h68, 32'h00000002, 4'h1);
    chk("dn_free", downstream_role_select_o, 32'h0);
    wr(8'h70, 32'h00000000, 4'hf);
    rd(8'h70, 32'h00006000);
    chk("user_en", {replay_user_en_o, ack_user_en_o}, 32'h0);
    wr(8'h70, 32'hffffffff, 4'hc);
    rd(8'h70, 32'h7fff6000);
    chk("ack_val", {ack_user_en_o, ack_latency_o}, 32'h7fff);
    wr(8'h70, 32'hffffffff, 4'h3);
    rd(8'h70, 32'h7fff7fff);
    chk("rpl_val", {replay_user_en_o, replay_timeout_o}, 32'h1fff);
    for (int i = 0; i < 32; i++) begin
      wr(8'h74, i, 4'h1);
      chk("fwd", {credit_all_types_o, arb_stay_o, ct_threshold_o, store_forward_o}, i);
    end
    wr(8'h74, 32'hffffffff, 4'hf);
    rd(8'h74, 32'h0000001f);
    wr(8'h6c, 32'h12345678, 4'h5);
    ce_i = 1'b0;
    wr(8'h6c, 32'h0, 4'hf);
    ce_i = 1'b1;
    chk("test1", test_ctrl1_o, 32'h04340878);
    rst_i = 1'b1;
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    @(negedge ref_clk_i);
    rd(8'h74, 32'h00000002);
    chk("train_rst", link_train_ok_o, 32'h0);
    conclude();
  end
endmodule : svcr_regs_bench
